/* mps_core.sv */
// Program sequencer, return stack, table read and banked data memory
// What this block does
// (RULE_01) Program memory is two 8K-word banks; bank select bit 5 picks bank.
// (RULE_02) Jumps and calls give 13 address bits; top bit from bank select bit 5.
// (RULE_03) Returns restore the whole 14-bit program counter from the stack.
// (RULE_04) After reset execution starts at address 000H.
// (RULE_05) External interrupt, enabled and stack not full, branches to 004H.
// (RULE_06) Timer 0 overflow interrupt branches to 008H when stack not full.
// (RULE_07) Timer 1 overflow interrupt branches to 00CH when stack not full.
// (RULE_08) Serial port interrupt branches to 010H when stack not full.
// (RULE_09) I2C interrupt branches to 014H when stack not full.
// (RULE_10) Shared multi-function interrupt branches to 018H when stack not full.
// (RULE_11) Table address is page pointer plus low pointer; last page forces ones.
// (RULE_12) Table read stores low byte at destination, high byte in read-only 08H.
// (RULE_13) Every table read takes two instruction cycles.
// (RULE_14) Hidden 16-entry stack pushes on call or interrupt, pops on returns.
// (RULE_15) With a full stack interrupt acknowledge waits until a return pops.
// (RULE_16) A call with a full stack still executes and overflows the stack.
// (RULE_17) RAM 40H-FFH has three 192-byte banks; banks 1, 2 via pointer one.
// (RULE_18) Locations below 40H are common to all banks; unused ones read 00H.
// (RULE_19) Single bits of data memory can be set or cleared individually.
// (RULE_20) Locations 00H and 02H reach RAM through pointers at 01H and 03H.
// (RULE_21) Indirect access to 00H or 02H reads 00H and writes nothing.
// (RULE_22) Software must not move data directly between the two indirect locations.
// (RULE_23) The program counter steps by one unless a transfer loads it.
// (RULE_24) Writing program counter low byte at 06H jumps within the page.
// (RULE_25) Of several pending interrupts the lowest vector is taken first.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ns
module mps_core
  import mps_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [APB_AW-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic op_valid_in,
  input wire mps_op_type op_code_in,
  input wire logic [ROM_BANK_W-1:0] op_target_in,
  input wire logic [7:0] op_dest_in,
  output logic op_ready_out,
  input wire logic [N_IRQ-1:0] irq_pend_in,
  output logic [N_IRQ-1:0] irq_ack_out,
  output logic stack_full_out,
  output logic [PC_W-1:0] prog_addr_out,
  input wire logic [PROG_W-1:0] prog_data_in
);

  // ==========================================================
  // Declarations
  logic [1:0] phase_reg;
  logic [PC_W-1:0] pc_reg;
  logic [PC_W-1:0] pc_next;
  logic [PC_W-1:0] prog_addr_reg;
  logic op_ready_reg;
  logic pcl_jump_reg;
  logic tbl_busy_reg;
  mps_ref_type tbl_ref_reg;
  logic [STK_AW:0] stk_cnt_reg;
  logic [PC_W-1:0] stk_top;
  logic [7:0] bank_select_reg;
  logic [7:0] ptr0_reg;
  logic [7:0] ptr1_reg;
  logic [7:0] table_low_pointer_reg;
  logic [7:0] table_page_pointer_reg;
  logic [7:0] table_high_byte_reg;
  mps_apb_type apb_state_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic apb_we_reg;
  logic [7:0] apb_wdata_reg;
  logic [N_IRQ-1:0] irq_ack_reg;
  logic stack_full_reg;
  logic first_cyc_reg;
  logic cyc_end;
  logic stk_full;
  logic irq_take;
  logic take_op;
  logic transfer;
  mps_op_type op_eff;
  logic [N_IRQ-1:0] irq_sel;
  logic [PC_W-1:0] irq_vec;
  logic push;
  logic pop;
  logic [PC_W-1:0] push_data;
  mps_ref_type apb_ref;
  logic apb_start;
  logic apb_err;
  logic [7:0] sfr_rdata;
  logic [7:0] ram_rdata;
  logic [7:0] apb_rd;
  logic [7:0] apb_mod;
  logic apb_commit;
  logic tbl_commit;
  logic commit_en;
  mps_ref_type commit_ref;
  logic [7:0] commit_data;
  logic pcl_wr;

  assign prdata_out = prdata_reg;
  assign pready_out = pready_reg;
  assign pslverr_out = pslverr_reg;
  assign op_ready_out = op_ready_reg;
  assign irq_ack_out = irq_ack_reg;
  assign stack_full_out = stack_full_reg;
  assign prog_addr_out = prog_addr_reg;

  // ==========================================================
  // Instruction cycle of four clocks
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      phase_reg <= PH_FIRST;
    end else begin
      phase_reg <= phase_reg + PH_ONE;
    end
  end

  assign cyc_end = (phase_reg == PH_LAST);
  assign op_eff = op_valid_in ? op_code_in : OP_NEXT;
  assign stk_full = (stk_cnt_reg == STK_FULL);
  assign irq_sel = irq_pend_in & (~irq_pend_in + IRQ_LSB); // RULE_25
  assign irq_take = cyc_end && op_ready_reg && !pcl_jump_reg && (|irq_pend_in)
                    && !stk_full; // RULE_15
  assign take_op = cyc_end && op_ready_reg && !pcl_jump_reg && !irq_take;
  assign transfer = irq_take || pcl_jump_reg || (take_op && (op_eff != OP_NEXT));

  always_comb begin
    irq_vec = PC_RESET;
    for (int i = 0; i < N_IRQ; i++) begin
      if (irq_sel[i]) begin
        irq_vec = IRQ_VECTOR[i]; // RULE_05 RULE_06 RULE_07 RULE_08 RULE_09 RULE_10
      end
    end
  end

  // ==========================================================
  // Program counter
  always_comb begin
    pc_next = pc_reg;
    if (pcl_wr) begin
      pc_next = {pc_reg[PC_W-1:8], commit_data}; // RULE_24
    end else if (irq_take) begin
      pc_next = irq_vec;
    end else if (take_op) begin
      unique case (op_eff)
        OP_NEXT, OP_TBL_PAGED, OP_TBL_LAST: pc_next = pc_reg + PC_ONE; // RULE_23
        OP_SKIP: pc_next = {pc_reg[PC_W-1], pc_reg[ROM_BANK_W-1:0] + SKIP_STEP};
        OP_GOTO, OP_CALL: pc_next = {bank_select_reg[BS_ROM_BIT], op_target_in}; // RULE_01 RULE_02
        OP_SUB_EXIT, OP_ISR_EXIT: pc_next = stk_top; // RULE_03
      endcase
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pc_reg <= PC_RESET; // RULE_04
    end else begin
      pc_reg <= pc_next;
    end
  end

  // Fetch address, borrowed by a table read for its second cycle
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      prog_addr_reg <= PC_RESET; // RULE_04
    end else if (cyc_end) begin
      if (take_op && (op_eff == OP_TBL_PAGED)) begin
        prog_addr_reg <= {table_page_pointer_reg[TBL_PAGE_W-1:0], table_low_pointer_reg}; // RULE_11
      end else if (take_op && (op_eff == OP_TBL_LAST)) begin
        prog_addr_reg <= {LAST_PAGE, table_low_pointer_reg}; // RULE_11
      end else begin
        prog_addr_reg <= pc_next;
      end
    end
  end

  // Dummy cycle after every control transfer or table read
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      op_ready_reg <= 1'b1;
    end else if (cyc_end) begin
      op_ready_reg <= !op_ready_reg || !transfer; // RULE_13
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pcl_jump_reg <= 1'b0;
    end else if (pcl_wr) begin
      pcl_jump_reg <= 1'b1;
    end else if (cyc_end) begin
      pcl_jump_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_ack_reg <= IRQ_NONE;
      stack_full_reg <= 1'b0;
      first_cyc_reg <= 1'b1;
    end else begin
      irq_ack_reg <= irq_take ? irq_sel : IRQ_NONE;
      stack_full_reg <= stk_full;
      if (cyc_end) begin
        first_cyc_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Return stack
  assign push = irq_take || (take_op && (op_eff == OP_CALL)); // RULE_14 RULE_16
  assign pop = take_op && ((op_eff == OP_SUB_EXIT) || (op_eff == OP_ISR_EXIT)); // RULE_14
  assign push_data = irq_take ? pc_reg : pc_reg + PC_ONE;

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      stk_cnt_reg <= STK_EMPTY;
    end else if (push && !stk_full) begin
      stk_cnt_reg <= stk_cnt_reg + STK_INC;
    end else if (pop && (stk_cnt_reg != STK_EMPTY)) begin
      stk_cnt_reg <= stk_cnt_reg - STK_INC; // RULE_15
    end
  end

  // Full stack overwrites the bottom slot on a call
  mps_mem #(.WIDTH(PC_W), .DEPTH(STK_DEPTH), .AW(STK_AW)) u_stack (
    .clk_in(mclk_in),
    .we_in(push),
    .waddr_in(stk_cnt_reg[STK_AW-1:0]),
    .wdata_in(push_data),
    .raddr_in(stk_cnt_reg[STK_AW-1:0] - STK_IDX_ONE),
    .rdata_out(stk_top)
  );

  // ==========================================================
  // Table read completion
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      tbl_busy_reg <= 1'b0;
      tbl_ref_reg <= '0;
    end else if (take_op && ((op_eff == OP_TBL_PAGED) || (op_eff == OP_TBL_LAST))) begin
      tbl_busy_reg <= 1'b1;
      tbl_ref_reg <= resolve(op_dest_in, ptr0_reg, ptr1_reg, bank_select_reg[1:0]);
    end else if (cyc_end) begin
      tbl_busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      table_high_byte_reg <= REG_RESET;
    end else if (cyc_end && tbl_busy_reg) begin
      table_high_byte_reg <= prog_data_in[PROG_W-1:8]; // RULE_12
    end
  end

  // ==========================================================
  // Single write port for registers and RAM
  assign apb_commit = (apb_state_reg == APB_DONE) && apb_we_reg;
  assign tbl_commit = cyc_end && tbl_busy_reg && !tbl_ref_reg.null_ref; // RULE_21
  assign commit_en = apb_commit || tbl_commit;
  assign commit_ref = tbl_commit ? tbl_ref_reg : apb_ref;
  assign commit_data = tbl_commit ? prog_data_in[7:0] : apb_wdata_reg; // RULE_12
  assign pcl_wr = commit_en && (commit_ref.loc == LOC_PCL);

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      bank_select_reg <= REG_RESET;
      ptr0_reg <= REG_RESET;
      ptr1_reg <= REG_RESET;
      table_low_pointer_reg <= REG_RESET;
      table_page_pointer_reg <= REG_RESET;
    end else if (commit_en) begin
      if (commit_ref.loc == LOC_BANK) begin
        bank_select_reg <= commit_data & BANK_MASK;
      end
      if (commit_ref.loc == LOC_PTR0) begin
        ptr0_reg <= commit_data;
      end
      if (commit_ref.loc == LOC_PTR1) begin
        ptr1_reg <= commit_data;
      end
      if (commit_ref.loc == LOC_TABLE_LOW_POINTER) begin
        table_low_pointer_reg <= commit_data;
      end
      if (commit_ref.loc == LOC_TABLE_PAGE_POINTER) begin
        table_page_pointer_reg <= commit_data;
      end
    end
  end

  mps_mem #(.WIDTH(8), .DEPTH(RAM_DEPTH), .AW(RAM_AW)) u_ram (
    .clk_in(mclk_in),
    .we_in(commit_en && ram_hit(commit_ref)), // RULE_17
    .waddr_in(ram_index(commit_ref)),
    .wdata_in(commit_data),
    .raddr_in(ram_index(apb_ref)),
    .rdata_out(ram_rdata)
  );

  // ==========================================================
  // APB slave, access aligned to the instruction cycle
  assign apb_ref = resolve(paddr_in[LOC_LSB+7:LOC_LSB], ptr0_reg, ptr1_reg,
                           bank_select_reg[1:0]); // RULE_20
  assign apb_err = paddr_in[UNMAP_BIT];
  assign apb_start = (apb_state_reg == APB_IDLE) && psel_in && penable_in
                     && (phase_reg == PH_APB);

  always_comb begin
    case (apb_ref.loc)
      LOC_PTR0: sfr_rdata = ptr0_reg;
      LOC_PTR1: sfr_rdata = ptr1_reg;
      LOC_BANK: sfr_rdata = bank_select_reg;
      LOC_PCL: sfr_rdata = pc_reg[7:0];
      LOC_TABLE_LOW_POINTER: sfr_rdata = table_low_pointer_reg;
      LOC_TABLE_HIGH_BYTE: sfr_rdata = table_high_byte_reg;
      LOC_TABLE_PAGE_POINTER: sfr_rdata = table_page_pointer_reg;
      default: sfr_rdata = ZERO_BYTE; // RULE_18
    endcase
  end

  always_comb begin
    apb_rd = ZERO_BYTE;
    if (apb_err || apb_ref.null_ref) begin
      apb_rd = ZERO_BYTE; // RULE_21
    end else if (apb_ref.loc < GP_BASE) begin
      apb_rd = sfr_rdata; // RULE_18
    end else if (ram_hit(apb_ref)) begin
      apb_rd = ram_rdata; // RULE_17
    end
    apb_mod = apb_rd;
    apb_mod[pwdata_in[2:0]] = pwdata_in[BIT_VAL_POS]; // RULE_19
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      apb_state_reg <= APB_IDLE;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
      apb_we_reg <= 1'b0;
      apb_wdata_reg <= ZERO_BYTE;
    end else begin
      unique case (apb_state_reg)
        APB_IDLE: begin
          if (apb_start) begin
            apb_state_reg <= APB_WAIT;
          end
        end
        APB_WAIT: begin
          apb_state_reg <= APB_DONE;
          pready_reg <= 1'b1;
          pslverr_reg <= apb_err;
          prdata_reg <= pwrite_in ? '0 : {PRDATA_PAD, apb_rd};
          apb_we_reg <= pwrite_in && !apb_err && !apb_ref.null_ref; // RULE_21
          apb_wdata_reg <= paddr_in[BITOP_BIT] ? apb_mod : pwdata_in[7:0]; // RULE_19
        end
        APB_DONE: begin
          apb_state_reg <= APB_IDLE;
          pready_reg <= 1'b0;
          pslverr_reg <= 1'b0;
          apb_we_reg <= 1'b0;
        end
        default: apb_state_reg <= APB_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  sequence s_tbl_take;
    take_op && ((op_eff == OP_TBL_PAGED) || (op_eff == OP_TBL_LAST));
  endsequence

  sequence s_dummy_then_ready;
    (!op_ready_reg)[*4] ##1 op_ready_reg;
  endsequence

  AST_RESET_START: assert property ( // RULE_04
    first_cyc_reg |-> (pc_reg == PC_RESET) && (prog_addr_reg == PC_RESET))
    else $error("execution did not start at address zero");

  AST_GOTO_BANK: assert property ( // RULE_02
    take_op && (op_eff == OP_GOTO) |=>
      pc_reg == {$past(bank_select_reg[BS_ROM_BIT]), $past(op_target_in)})
    else $error("jump target not formed from bank bit and 13 bits");

  AST_RETURN_FULL: assert property ( // RULE_03
    pop |=> (pc_reg == $past(stk_top)) && (prog_addr_reg == $past(stk_top)))
    else $error("return did not restore full program counter");

  AST_IRQ_VECTOR: assert property ( // RULE_05
    irq_take |=> (prog_addr_reg == $past(irq_vec)) && (irq_ack_reg == $past(irq_sel)))
    else $error("interrupt did not branch to its vector");

  AST_IRQ_PRIORITY: assert property ( // RULE_25
    (|irq_ack_reg) |-> $onehot(irq_ack_reg)
      && (((irq_ack_reg - IRQ_LSB) & $past(irq_pend_in)) == IRQ_NONE))
    else $error("interrupt acknowledged out of priority");

  AST_FULL_HOLD: assert property ( // RULE_15
    cyc_end && stk_full |=> (irq_ack_reg == IRQ_NONE) && (stk_cnt_reg != STK_EMPTY))
    else $error("interrupt acknowledged with full stack");

  AST_TWO_CYCLES: assert property ( // RULE_13
    s_tbl_take |=> s_dummy_then_ready)
    else $error("table read did not take two instruction cycles");

  AST_TBL_PAGE: assert property ( // RULE_11
    take_op && (op_eff == OP_TBL_LAST) |=>
      (prog_addr_reg[PC_W-1:8] == LAST_PAGE) && (prog_addr_reg[7:0] == $past(table_low_pointer_reg)))
    else $error("last page table address wrong");

  AST_TBL_HIGH: assert property ( // RULE_12
    cyc_end && tbl_busy_reg |=> table_high_byte_reg == $past(prog_data_in[PROG_W-1:8]))
    else $error("table high byte not captured");

  AST_INCREMENT: assert property ( // RULE_23
    take_op && (op_eff == OP_NEXT) |=> pc_reg == $past(pc_reg) + PC_ONE)
    else $error("program counter did not step by one");

  AST_PUSH: assert property ( // RULE_14
    push && !stk_full |=> stk_cnt_reg == $past(stk_cnt_reg) + STK_INC)
    else $error("stack index did not advance on push");

  AST_IND_NULL: assert property ( // RULE_21
    (apb_state_reg == APB_WAIT) && apb_ref.null_ref |=> (prdata_reg == '0) && !apb_we_reg)
    else $error("indirect access to indirect location not nulled");

  AST_PCL_JUMP: assert property ( // RULE_24
    pcl_wr |=> (pc_reg[PC_W-1:8] == $past(pc_reg[PC_W-1:8]))
      && (pc_reg[7:0] == $past(commit_data)))
    else $error("short jump left the page");

endmodule

/* mps_pkg.sv */
// Constants, types and helper functions for the program sequencing core
package mps_pkg;

  // ==========================================================
  // Program counter and program memory
  localparam int PC_W = 14;
  localparam int ROM_BANK_W = 13;
  localparam int PROG_W = 16;
  localparam int TBL_PAGE_W = 6;
  localparam logic [PC_W-1:0] PC_RESET = 14'h0000;
  localparam logic [PC_W-1:0] PC_ONE = 14'h0001;
  localparam logic [ROM_BANK_W-1:0] SKIP_STEP = 13'h0002;
  localparam logic [TBL_PAGE_W-1:0] LAST_PAGE = 6'h3F;
  localparam int BS_ROM_BIT = 5;

  // ==========================================================
  // Interrupt vectors, lowest index has highest priority
  localparam int N_IRQ = 6;
  localparam logic [N_IRQ-1:0] IRQ_LSB = 6'h01;
  localparam logic [N_IRQ-1:0] IRQ_NONE = 6'h00;
  localparam logic [N_IRQ-1:0][PC_W-1:0] IRQ_VECTOR = {
    14'h0018, 14'h0014, 14'h0010, 14'h000C, 14'h0008, 14'h0004
  };

  // ==========================================================
  // Return stack
  localparam int STK_DEPTH = 16;
  localparam int STK_AW = 4;
  localparam logic [STK_AW:0] STK_FULL = 5'h10;
  localparam logic [STK_AW:0] STK_EMPTY = 5'h00;
  localparam logic [STK_AW:0] STK_INC = 5'h01;
  localparam logic [STK_AW-1:0] STK_IDX_ONE = 4'h1;

  // ==========================================================
  // Data memory map, locations are register indices
  localparam int RAM_DEPTH = 576;
  localparam int RAM_AW = 10;
  localparam logic [RAM_AW-1:0] RAM_BANK_SIZE = 10'h0C0;
  localparam logic [1:0] RAM_BANKS = 2'h3;
  localparam logic [7:0] GP_BASE = 8'h40;
  localparam logic [7:0] LOC_IND0 = 8'h00;
  localparam logic [7:0] LOC_PTR0 = 8'h01;
  localparam logic [7:0] LOC_IND1 = 8'h02;
  localparam logic [7:0] LOC_PTR1 = 8'h03;
  localparam logic [7:0] LOC_BANK = 8'h04;
  localparam logic [7:0] LOC_PCL = 8'h06;
  localparam logic [7:0] LOC_TABLE_LOW_POINTER = 8'h07;
  localparam logic [7:0] LOC_TABLE_HIGH_BYTE = 8'h08;
  localparam logic [7:0] LOC_TABLE_PAGE_POINTER = 8'h1F;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] BANK_MASK = 8'h23;

  // ==========================================================
  // APB decode and instruction cycle phases
  localparam int APB_AW = 12;
  localparam int LOC_LSB = 2;
  localparam int BITOP_BIT = 10;
  localparam int UNMAP_BIT = 11;
  localparam int BIT_VAL_POS = 3;
  localparam logic [23:0] PRDATA_PAD = 24'h000000;
  localparam logic [1:0] PH_FIRST = 2'h0;
  localparam logic [1:0] PH_ONE = 2'h1;
  localparam logic [1:0] PH_APB = 2'h0;
  localparam logic [1:0] PH_LAST = 2'h3;

  typedef enum logic [2:0] {
    OP_NEXT = 3'h0,
    OP_SKIP = 3'h1,
    OP_GOTO = 3'h3,
    OP_CALL = 3'h2,
    OP_SUB_EXIT = 3'h6,
    OP_ISR_EXIT = 3'h7,
    OP_TBL_PAGED = 3'h5,
    OP_TBL_LAST = 3'h4
  } mps_op_type;

  typedef enum logic [1:0] {
    APB_IDLE = 2'b00,
    APB_WAIT = 2'b01,
    APB_DONE = 2'b11
  } mps_apb_type;

  typedef struct packed {
    logic null_ref;
    logic [1:0] bank;
    logic [7:0] loc;
  } mps_ref_type;

  // Follow an indirect location through its pointer
  function automatic mps_ref_type resolve(input logic [7:0] loc, input logic [7:0] ptr0,
                                          input logic [7:0] ptr1, input logic [1:0] bank);
    mps_ref_type r;
    r.null_ref = 1'b0;
    r.bank = 2'h0;
    r.loc = loc;
    if (loc == LOC_IND0) begin
      r.loc = ptr0;
    end else if (loc == LOC_IND1) begin
      r.loc = ptr1;
      r.bank = bank;
    end
    if ((loc == LOC_IND0) || (loc == LOC_IND1)) begin
      r.null_ref = (r.loc == LOC_IND0) || (r.loc == LOC_IND1);
    end
    return r;
  endfunction

  function automatic logic ram_hit(input mps_ref_type r);
    return (r.loc >= GP_BASE) && (r.bank < RAM_BANKS);
  endfunction

  function automatic logic [RAM_AW-1:0] ram_index(input mps_ref_type r);
    return RAM_AW'(r.bank) * RAM_BANK_SIZE + RAM_AW'(r.loc - GP_BASE);
  endfunction

endpackage

/* mps_mem.sv */
// Simple dual-port memory with registered read data
`timescale 1ns/1ns
module mps_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk_in,
  input wire logic we_in,
  input wire logic [AW-1:0] waddr_in,
  input wire logic [WIDTH-1:0] wdata_in,
  input wire logic [AW-1:0] raddr_in,
  output logic [WIDTH-1:0] rdata_out
);

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk_in) begin
    if (we_in) begin
      mem[waddr_in] <= wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    rdata_out <= mem[raddr_in];
  end

endmodule

/* mps_core_tb.sv */
// Self-checking bench for the program sequencing core
`timescale 1ns/1ns
module mcu_program_sequencing_and_memory_tb_top
  import mps_pkg::*;
;
  logic mclk_in = 0, rst_in = 1, psel = 0, pen = 0, pwr = 0, opv = 0;
  logic [11:0] pad = 0;
  logic [31:0] pwd = 0, prd, rd;
  mps_op_type opc = OP_NEXT;
  logic [12:0] opt = 0;
  logic [7:0] opd = 0, a, b, l;
  logic [5:0] irq = 0, ack, p;
  logic [15:0] pdat = 0, w;
  logic [13:0] pa;
  logic [1:0] ph;
  logic prdy, perr, opr, sfull, err;
  int fail_count = 0, cmp_count = 0, n;

  mps_core u_mps_core (.mclk_in(mclk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(pen),
    .pwrite_in(pwr), .paddr_in(pad), .pwdata_in(pwd), .prdata_out(prd), .pready_out(prdy),
    .pslverr_out(perr), .op_valid_in(opv), .op_code_in(opc), .op_target_in(opt),
    .op_dest_in(opd), .op_ready_out(opr), .irq_pend_in(irq), .irq_ack_out(ack),
    .stack_full_out(sfull), .prog_addr_out(pa), .prog_data_in(pdat));

  initial begin
    forever #4 mclk_in = ~mclk_in;
  end
  // Phase of the coming edge
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) ph <= 2'h0;
    else ph <= ph + 2'h1;
  end

  task bad(input string m);
    fail_count++;
    $display("wrong value at %0t: %s", $time, m);
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e, input string m);
    cmp_count++;
    if (g !== e) bad(m);
  endtask
  task print_verdict;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task reset_dut;
    @(posedge mclk_in) rst_in <= 1'b1;
    repeat (12) @(posedge mclk_in);
    rst_in <= 1'b0;
  endtask
  // APB transfer, request held until pready is sampled high at a rising edge
  task apb(input logic wr_en, input logic [11:0] ad, input logic [7:0] d);
    @(posedge mclk_in);
    {psel, pen, pwr, pad, pwd} <= {2'b10, wr_en, ad, 24'h000000, d};
    @(posedge mclk_in) pen <= 1'b1;
    n = 0;
    do begin @(posedge mclk_in); n++; end while (prdy !== 1'b1 && n < 50);
    if (n >= 50) bad("bus hang");
    rd = prd;
    err = perr;
    {psel, pen} <= 2'b00;
  endtask
  task wr(input logic [7:0] loc, input logic [7:0] d);
    apb(1'b1, {2'b00, loc, 2'b00}, d);
  endtask
  task rdc(input logic [7:0] loc, input logic [7:0] e, input string m);
    apb(1'b0, {2'b00, loc, 2'b00}, 8'h00);
    chk(rd, {24'h000000, e}, m);
  endtask
  task op(input mps_op_type c, input logic [12:0] t, input logic [7:0] d);
    @(posedge mclk_in) {opv, opc, opt, opd} <= {1'b1, c, t, d};
    n = 0;
    do begin @(negedge mclk_in); n++; end while (!(ph == 2'h3 && opr === 1'b1) && n < 50);
    if (n >= 50) bad("op hang");
    @(posedge mclk_in) {opv, opc} <= {1'b0, OP_NEXT};
    @(negedge mclk_in);
  endtask
  task wait_ack;
    n = 0;
    do begin @(negedge mclk_in); n++; end while (ack === 6'h00 && n < 60);
  endtask

  initial begin
    #300000;
    fail_count++;
    print_verdict;
  end

  initial begin
    n = $urandom(50);
    reset_dut;
    @(negedge mclk_in) chk(pa, 14'h0000, "start address");
    a = $urandom;
    b = $urandom;
    wr(8'h04, 8'h01);
    wr(8'h50, a);
    wr(8'h03, 8'h50);
    wr(8'h02, b);
    rdc(8'h50, a, "bank 0 data");
    rdc(8'h02, b, "bank 1 via pointer");
    apb(1'b1, 12'h540, 8'h09);
    rdc(8'h50, a | 8'h02, "bit set");
    apb(1'b1, 12'h540, 8'h07);
    rdc(8'h50, (a | 8'h02) & 8'h7F, "bit clear");
    wr(8'h01, 8'h02);
    rdc(8'h00, 8'h00, "null pointer read");
    wr(8'h30, 8'h5A);
    rdc(8'h30, 8'h00, "unused location");
    apb(1'b0, 12'h800, 8'h00);
    chk(err, 1, "unmapped error");
    $display("test data memory done");
    wr(8'h04, 8'h20);
    op(OP_GOTO, 13'h1A50, 8'h00);
    chk(pa, 14'h3A50, "goto bank");
    wr(8'h06, a);
    @(posedge mclk_in);
    @(negedge mclk_in) chk(pa, {6'h3A, a}, "short jump");
    op(OP_SKIP, 13'h0000, 8'h00);
    chk(pa, 14'h3A02 + a, "skip in bank");
    wr(8'h04, 8'h00);
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk_in) irq <= 6'h01 << i;
      wait_ack;
      chk(ack, 6'h01 << i, "ack");
      chk(pa, 14'(4 * (i + 1)), "vector");
      @(posedge mclk_in) irq <= 6'h00;
      op(OP_ISR_EXIT, 13'h0000, 8'h00);
      chk(pa[13], 1'b1, "return bank");
    end
    @(posedge mclk_in) irq <= 6'h14;
    wait_ack;
    chk(ack, 6'h04, "priority");
    @(posedge mclk_in) irq <= 6'h00;
    op(OP_ISR_EXIT, 13'h0000, 8'h00);
    $display("test vectors done");
    w = $urandom;
    l = $urandom;
    p = $urandom;
    @(posedge mclk_in) pdat <= w;
    wr(8'h07, l);
    wr(8'h1F, {2'b00, p});
    op(OP_TBL_PAGED, 13'h0000, 8'h60);
    chk(pa, {p, l}, "paged table address");
    chk(opr, 1'b0, "second cycle");
    repeat (8) @(posedge mclk_in);
    rdc(8'h60, w[7:0], "table low");
    wr(8'h08, 8'hA5);
    rdc(8'h08, w[15:8], "table high");
    op(OP_TBL_LAST, 13'h0000, 8'h61);
    chk(pa, {6'h3F, l}, "last page address");
    $display("test table done");
    reset_dut;
    for (int i = 0; i < 16; i++) op(OP_CALL, 13'h0100, 8'h00);
    repeat (8) @(posedge mclk_in);
    chk(sfull, 1'b1, "stack full");
    op(OP_CALL, 13'h0200, 8'h00);
    chk(pa, 14'h0200, "overflow call");
    @(posedge mclk_in) irq <= 6'h02;
    repeat (12) @(negedge mclk_in) chk(ack, 6'h00, "ack held");
    op(OP_SUB_EXIT, 13'h0000, 8'h00);
    chk(pa, 14'h0101, "return address");
    wait_ack;
    chk(ack, 6'h02, "ack after pop");
    @(posedge mclk_in) irq <= 6'h00;
    $display("test stack done");
    print_verdict;
  end
endmodule
